//--- include/flash_pkg.sv
// Shared constants for the flash page program link and its two ends.
package flash_pkg;
    localparam int           CLK_KHZ           = 100000;
    localparam int           ERASE_PROG_MS     = 35;
    localparam int           ERASE_PROG_BIG_MS = 40;
    localparam int           PROG_ONLY_MS      = 4;
    localparam int           PROG_ONLY_BIG_MS  = 6;
    localparam int           ERASE_PROG_CYC    = ERASE_PROG_MS * CLK_KHZ;
    localparam int           PROG_ONLY_CYC     = PROG_ONLY_MS * CLK_KHZ;
    localparam int           TIMER_W           = 23;
    localparam int           PAGE_BYTES        = 264;
    localparam int           BYTE_W            = 9;
    localparam int           PAGE_SEL_W        = 4;
    localparam int           FLASH_PAGES       = 16;
    localparam int           HEADER_BITS       = 32;
    localparam int           OPCODE_BITS       = 8;
    localparam int           STATUS_READY_BIT  = 7;
    localparam int           HALF_PERIOD       = 8;
    localparam int           GUARD_CYCLES      = 8;
    localparam logic [7:0]   OP_THRU_B1        = 8'h82;
    localparam logic [7:0]   OP_ERASE_B1       = 8'h83;
    localparam logic [7:0]   OP_THRU_B2        = 8'h85;
    localparam logic [7:0]   OP_ERASE_B2       = 8'h86;
    localparam logic [7:0]   OP_NOERASE_B1     = 8'h88;
    localparam logic [7:0]   OP_NOERASE_B2     = 8'h89;
    localparam logic [7:0]   ERASED_BYTE       = 8'hff;
    localparam logic [BYTE_W-1:0] LAST_BYTE    = 9'h107;

    // Commands that carry write data after the address.
    function automatic logic cmd_has_data(input logic [7:0] op);
        return (op == OP_THRU_B1) || (op == OP_THRU_B2);
    endfunction
endpackage

//--- include/flash_link_if.sv
// Serial command link between the master end and the flash device end.
interface flash_link_if;
    logic chip_select_n;
    logic serial_clk;
    logic mosi;
    logic flash_ready;

    modport device (input chip_select_n, input serial_clk, input mosi, output flash_ready);
    modport master (output chip_select_n, output serial_clk, output mosi, input flash_ready);
endinterface

//--- src/link_sync.sv
// Two flip-flop synchroniser for link inputs from another clock domain.
module link_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Both stages reset to zero; the reset_val_in input flips the sense so idle-high
    // pins read as their idle level without a port value under reset.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in ^ reset_val_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg ^ reset_val_in;
endmodule

//--- src/flash_device_end.sv
// Flash device end: decodes buffer-to-page program commands and runs them self-timed.
//
// Overview of operation
// - Master drops select while serial clock high.
// - Master shifts opcode MSB first, falling edges.
// - 0x83/0x86 erase-program from buffer one/two.
// - 0x89 programs erased page from buffer two.
// - Master sends 24-bit address; low byte ignored.
// - Master raises select on a falling edge.
// - Select stays low for the whole command.
// - Operation starts only on select rising.
// - Erase then program; up to 35/40 ms.
// - Program without erase; up to 4/6 ms.
// - Status bit 7 shows busy until done.
// - 0x82/0x85 write buffer then erase-program.
// - Combined command address holds page and byte.
// - Master shifts data bytes MSB first after address.
// - First byte at start, counter steps per byte.
// - Buffer counter wraps past the last location.
// - Unwritten buffer bytes keep and program old values.
// - Combined command shows busy until erase-program ends.
// - Single-buffer build rejects all buffer-two opcodes.
module flash_device_end #(
    parameter int   ERASE_PROG_CYCLES = flash_pkg::ERASE_PROG_CYC,
    parameter int   PROG_ONLY_CYCLES  = flash_pkg::PROG_ONLY_CYC,
    parameter logic DUAL_BUFFER       = 1'b1
) (
    input  wire logic                            sys_clk_in,
    input  wire logic                            rst_b_in,
    flash_link_if.device                         link,
    input  wire logic [flash_pkg::PAGE_SEL_W-1:0] rd_page_in,
    input  wire logic [flash_pkg::BYTE_W-1:0]     rd_byte_in,
    output logic      [7:0]                      rd_data_out,
    output logic      [7:0]                      status_out
);
    import flash_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ERASE   = 2'b01,
        ST_PROGRAM = 2'b10,
        ST_SETTLE  = 2'b11
    } op_state_t;

    // Decoded command: {valid, erase, buffer two, carries data}.
    typedef struct packed {
        logic valid;
        logic erase;
        logic buf_two;
        logic thru;
    } cmd_t;

    function automatic cmd_t decode(input logic [7:0] op);
        cmd_t c;
        c = '0;
        unique case (op)
            OP_ERASE_B1:   c = '{1'b1, 1'b1, 1'b0, 1'b0};
            OP_ERASE_B2:   c = '{1'b1, 1'b1, 1'b1, 1'b0};
            OP_NOERASE_B1: c = '{1'b1, 1'b0, 1'b0, 1'b0};
            OP_NOERASE_B2: c = '{1'b1, 1'b0, 1'b1, 1'b0};
            OP_THRU_B1:    c = '{1'b1, 1'b1, 1'b0, 1'b1};
            OP_THRU_B2:    c = '{1'b1, 1'b1, 1'b1, 1'b1};
            default:       c = '0;
        endcase
        if (c.buf_two && !DUAL_BUFFER) begin
            c = '0;
        end
        return c;
    endfunction

    function automatic logic [BYTE_W-1:0] step_ptr(input logic [BYTE_W-1:0] p);
        return (p >= LAST_BYTE) ? '0 : p + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link sampling.

    logic [2:0] pins_sync;
    logic       sck_s;
    logic       cs_n_s;
    logic       mosi_s;

    link_sync #(
        .WIDTH (3)
    ) u_sync (
        .sys_clk_in   (sys_clk_in),
        .rst_b_in     (rst_b_in),
        .async_in     ({link.serial_clk, link.chip_select_n, link.mosi}),
        .reset_val_in (3'h6),
        .sync_out     (pins_sync)
    );

    assign {sck_s, cs_n_s, mosi_s} = pins_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Storage: two page buffers and a small flash array.

    logic [7:0] buf_mem   [2][PAGE_BYTES];
    logic [7:0] flash_mem [FLASH_PAGES*PAGE_BYTES];

    ////////////////////////////////////////////////////////////////////////////
    // Frame and operation state.

    logic                  sck_prev_reg,  sck_prev_next;
    logic                  cs_prev_reg,   cs_prev_next;
    logic [5:0]            bit_cnt_reg,   bit_cnt_next;
    logic [31:0]           shift_reg,     shift_next;
    logic [7:0]            opcode_reg,    opcode_next;
    logic [PAGE_SEL_W-1:0] page_reg,      page_next;
    logic [BYTE_W-1:0]     ptr_reg,       ptr_next;
    op_state_t             state_reg,     state_next;
    cmd_t                  cmd_reg,       cmd_next;
    logic [BYTE_W-1:0]     idx_reg,       idx_next;
    logic [TIMER_W-1:0]    timer_reg,     timer_next;
    logic [7:0]            rd_data_next;

    logic                  sck_rise;
    logic                  cs_rise;
    logic                  cs_fall;
    logic [31:0]           shifted;
    cmd_t                  frame_cmd;
    logic                  buf_we;
    logic [7:0]            buf_wdata;
    logic                  flash_we;
    logic [7:0]            flash_wdata;
    logic [7:0]            flash_old;
    logic [7:0]            buf_rd;
    int unsigned           flash_addr;

    assign flash_addr = int'(page_reg) * PAGE_BYTES + int'(idx_reg);
    assign flash_old  = flash_mem[flash_addr];
    assign buf_rd     = buf_mem[cmd_reg.buf_two][idx_reg];

    always_comb begin
        sck_prev_next = sck_s;
        cs_prev_next  = cs_n_s;
        sck_rise      = sck_s && !sck_prev_reg;
        cs_rise       = cs_n_s && !cs_prev_reg;
        cs_fall       = !cs_n_s && cs_prev_reg;
        shifted       = {shift_reg[30:0], mosi_s};
        frame_cmd     = decode(opcode_reg);
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        opcode_next   = opcode_reg;
        page_next     = page_reg;
        ptr_next      = ptr_reg;
        state_next    = state_reg;
        cmd_next      = cmd_reg;
        idx_next      = idx_reg;
        timer_next    = timer_reg;
        buf_we        = 1'b0;
        buf_wdata     = shifted[7:0];
        flash_we      = 1'b0;
        flash_wdata   = ERASED_BYTE;
        rd_data_next  = flash_mem[int'(rd_page_in) * PAGE_BYTES + int'(rd_byte_in)];

        // A frame restarts its bit count when select falls; bits are taken
        // on rising serial clock edges only while select is low.
        if (cs_fall) begin
            bit_cnt_next = '0;
        end else if (sck_rise && !cs_n_s && state_reg == ST_IDLE) begin
            shift_next = shifted;
            if (bit_cnt_reg < 6'(HEADER_BITS)) begin
                bit_cnt_next = bit_cnt_reg + 6'h01;
            end else begin
                bit_cnt_next = bit_cnt_reg + 6'h01;
                if (bit_cnt_reg == 6'(HEADER_BITS + OPCODE_BITS - 1)) begin
                    bit_cnt_next = 6'(HEADER_BITS);
                end
            end
            if (bit_cnt_reg == 6'(OPCODE_BITS - 1)) begin
                opcode_next = shifted[7:0];
            end
            if (bit_cnt_reg == 6'(HEADER_BITS - 1)) begin
                // Page above the byte field; the byte field matters only for
                // the combined command.
                page_next = shifted[BYTE_W +: PAGE_SEL_W];
                ptr_next  = (shifted[BYTE_W-1:0] > LAST_BYTE) ? '0
                                                            : shifted[BYTE_W-1:0];
            end
            if (bit_cnt_reg == 6'(HEADER_BITS + OPCODE_BITS - 1) && frame_cmd.thru) begin
                buf_we   = 1'b1;
                ptr_next = step_ptr(ptr_reg);
            end
        end

        unique case (state_reg)
            ST_IDLE: begin
                // Only the end of a complete header launches anything.
                if (cs_rise && bit_cnt_reg >= 6'(HEADER_BITS) && frame_cmd.valid) begin
                    cmd_next   = frame_cmd;
                    idx_next   = '0;
                    state_next = frame_cmd.erase ? ST_ERASE : ST_PROGRAM;
                    timer_next = frame_cmd.erase ? TIMER_W'(ERASE_PROG_CYCLES)
                                                 : TIMER_W'(PROG_ONLY_CYCLES);
                end
            end
            ST_ERASE: begin
                flash_we = 1'b1;
                idx_next = step_ptr(idx_reg);
                if (idx_reg == LAST_BYTE) begin
                    state_next = ST_PROGRAM;
                end
            end
            ST_PROGRAM: begin
                // Programming can only clear bits, so an unerased page ends up
                // as the AND of old and new data.
                flash_we    = 1'b1;
                flash_wdata = flash_old & buf_rd;
                idx_next    = step_ptr(idx_reg);
                if (idx_reg == LAST_BYTE) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (timer_reg == '0) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (state_reg != ST_IDLE && timer_reg != '0) begin
            timer_next = timer_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_prev_reg <= 1'b1;
            cs_prev_reg  <= 1'b1;
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            opcode_reg   <= '0;
            page_reg     <= '0;
            ptr_reg      <= '0;
            state_reg    <= ST_IDLE;
            cmd_reg      <= '0;
            idx_reg      <= '0;
            timer_reg    <= '0;
            rd_data_out  <= '0;
        end else begin
            sck_prev_reg <= sck_prev_next;
            cs_prev_reg  <= cs_prev_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            opcode_reg   <= opcode_next;
            page_reg     <= page_next;
            ptr_reg      <= ptr_next;
            state_reg    <= state_next;
            cmd_reg      <= cmd_next;
            idx_reg      <= idx_next;
            timer_reg    <= timer_next;
            rd_data_out  <= rd_data_next;
        end
    end

    // Memories hold no reset; contents are undefined until written.
    always_ff @(posedge sys_clk_in) begin
        if (buf_we) begin
            buf_mem[frame_cmd.buf_two][ptr_reg] <= buf_wdata;
        end
        if (flash_we) begin
            flash_mem[flash_addr] <= flash_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status: bit 7 high means ready.

    always_comb begin
        status_out                   = '0;
        status_out[STATUS_READY_BIT] = (state_reg == ST_IDLE);
    end

    assign link.flash_ready = status_out[STATUS_READY_BIT];
endmodule

//--- src/flash_master_end.sv
// Master end: frames opcode, address and write data on the serial link.
module flash_master_end (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    flash_link_if.master     link,
    input  wire logic        cmd_valid_in,
    output logic             cmd_ready_out,
    input  wire logic [7:0]  opcode_in,
    input  wire logic [23:0] addr_in,
    input  wire logic        data_valid_in,
    output logic             data_ready_out,
    input  wire logic [7:0]  data_in,
    input  wire logic        data_last_in,
    output logic             flash_ready_out
);
    import flash_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE   = 3'b000,
        M_SELECT = 3'b001,
        M_LOW    = 3'b010,
        M_HIGH   = 3'b011,
        M_LOAD   = 3'b100,
        M_FINISH = 3'b101,
        M_GUARD  = 3'b110
    } m_state_t;

    m_state_t    state_reg, state_next;
    logic [3:0]  cnt_reg,   cnt_next;
    logic [31:0] shift_reg, shift_next;
    logic [5:0]  bits_reg,  bits_next;
    logic        more_reg,  more_next;
    logic        sck_reg,   sck_next;
    logic        cs_n_reg,  cs_n_next;
    logic        ready_s;
    logic        done;

    link_sync #(
        .WIDTH (1)
    ) u_sync (
        .sys_clk_in   (sys_clk_in),
        .rst_b_in     (rst_b_in),
        .async_in     (link.flash_ready),
        .reset_val_in (1'b0),
        .sync_out     (ready_s)
    );

    assign flash_ready_out = ready_s;
    // The guard state covers the device's sampling delay so a stale ready is not trusted.
    assign cmd_ready_out   = (state_reg == M_IDLE) && ready_s;
    assign data_ready_out  = (state_reg == M_LOAD);
    assign done            = (cnt_reg == 4'(HALF_PERIOD - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer; the serial clock is this clock divided by two half periods.

    always_comb begin
        state_next = state_reg;
        cnt_next   = done ? '0 : cnt_reg + 4'h1;
        shift_next = shift_reg;
        bits_next  = bits_reg;
        more_next  = more_reg;
        unique case (state_reg)
            M_IDLE: begin
                cnt_next = '0;
                if (cmd_valid_in && cmd_ready_out) begin
                    shift_next = {opcode_in, addr_in};
                    bits_next  = 6'(HEADER_BITS);
                    more_next  = cmd_has_data(opcode_in);
                    state_next = M_SELECT;
                end
            end
            M_SELECT: begin
                if (done) begin
                    state_next = M_LOW;
                end
            end
            M_LOW: begin
                if (done) begin
                    state_next = M_HIGH;
                end
            end
            M_HIGH: begin
                if (done) begin
                    bits_next  = bits_reg - 6'h01;
                    if (bits_reg != 6'h01) begin
                        shift_next = {shift_reg[30:0], 1'b0};
                        state_next = M_LOW;
                    end else begin
                        state_next = more_reg ? M_LOAD : M_FINISH;
                    end
                end
            end
            M_LOAD: begin
                // The clock rests high here, stalling the frame until data comes.
                cnt_next = '0;
                if (data_valid_in) begin
                    shift_next[31:24] = data_in;
                    bits_next         = 6'(OPCODE_BITS);
                    more_next         = !data_last_in;
                    state_next        = M_LOW;
                end
            end
            M_FINISH: begin
                if (done) begin
                    state_next = M_GUARD;
                end
            end
            M_GUARD: begin
                if (cnt_reg == 4'(GUARD_CYCLES - 1)) begin
                    state_next = M_IDLE;
                end
            end
            default: begin
                state_next = M_IDLE;
            end
        endcase
        // Select rises together with the last falling clock edge.
        sck_next  = !(state_next == M_LOW || state_next == M_FINISH);
        cs_n_next = (state_next == M_IDLE || state_next == M_FINISH
                     || state_next == M_GUARD);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= M_IDLE;
            cnt_reg   <= '0;
            shift_reg <= '0;
            bits_reg  <= '0;
            more_reg  <= 1'b0;
            sck_reg   <= 1'b1;
            cs_n_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            bits_reg  <= bits_next;
            more_reg  <= more_next;
            sck_reg   <= sck_next;
            cs_n_reg  <= cs_n_next;
        end
    end

    assign link.serial_clk    = sck_reg;
    assign link.chip_select_n = cs_n_reg;
    assign link.mosi          = shift_reg[31];
endmodule

//--- testbench/flash_link_properties.sv
// Timing checks on the serial link between the master end and the device end.
module flash_link_properties #(
    parameter int ERASE_PROG_CYCLES = 600,
    parameter int PROG_ONLY_CYCLES  = 300
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic mosi,
    input wire logic flash_ready
);
    ////////////////////////////////////////////////////////////////////////////////
    logic        sck_reg, sck_next;
    logic [15:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0]  hi_cnt_reg, hi_cnt_next;
    logic [23:0] busy_cnt_reg, busy_cnt_next;

    // The busy counter saturates so that a stuck busy line cannot wrap into a pass.
    always_comb begin
        sck_next      = serial_clk;
        bit_cnt_next  = chip_select_n ? 16'h0000 : bit_cnt_reg + {15'h0000, serial_clk & ~sck_reg};
        hi_cnt_next   = !chip_select_n ? 8'h00 : hi_cnt_reg + {7'h00, hi_cnt_reg != 8'hff};
        busy_cnt_next = flash_ready ? 24'h000000 : busy_cnt_reg + {23'h000000, ~&busy_cnt_reg};
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_reg      <= 1'b1;
            bit_cnt_reg  <= 16'h0000;
            hi_cnt_reg   <= 8'hff;
            busy_cnt_reg <= 24'h000000;
        end else begin
            sck_reg      <= sck_next;
            bit_cnt_reg  <= bit_cnt_next;
            hi_cnt_reg   <= hi_cnt_next;
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_select_clock_high: assert property ($fell(chip_select_n) |-> serial_clk)
        else $error("select fell while serial clock low");
    a_select_rise_fall: assert property ($rose(chip_select_n) |-> $fell(serial_clk))
        else $error("select rose off a falling serial clock edge");
    a_low_phase_len: assert property ($fell(serial_clk) |-> !serial_clk [*8] ##1 serial_clk)
        else $error("serial clock low phase not eight cycles");
    a_high_phase_len: assert property ($rose(serial_clk) && !chip_select_n |-> serial_clk [*8])
        else $error("serial clock high phase too short");
    a_mosi_on_fall: assert property ($changed(mosi) && !chip_select_n
        |-> $fell(serial_clk) || $fell(chip_select_n))
        else $error("serial data changed away from a falling clock edge");
    a_frame_whole_bytes: assert property ($rose(chip_select_n)
        |-> bit_cnt_reg >= 16'd32 && bit_cnt_reg[2:0] == 3'h0)
        else $error("frame ended off a byte boundary or before the address");
    a_busy_after_select: assert property ($fell(flash_ready)
        |-> chip_select_n && hi_cnt_reg >= 8'd1 && hi_cnt_reg <= 8'd8)
        else $error("busy began away from the select rising edge");
    a_busy_upper_bound: assert property (busy_cnt_reg <= ERASE_PROG_CYCLES + 8)
        else $error("self-timed operation ran past its maximum");
    a_busy_lower_bound: assert property ($rose(flash_ready)
        |-> busy_cnt_reg >= PROG_ONLY_CYCLES - 2)
        else $error("self-timed operation ended too soon");
    a_no_frame_busy: assert property (!flash_ready |-> chip_select_n)
        else $error("frame started while the device was busy");

    c_busy_seen: cover property ($fell(flash_ready));
    c_data_frame: cover property ($rose(chip_select_n) && bit_cnt_reg > 16'd32);
    c_long_busy: cover property ($rose(flash_ready) && busy_cnt_reg > PROG_ONLY_CYCLES + 8);
endmodule

//--- testbench/testbench.sv
// Bench for the master and device ends joined over the serial link.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_pkg::*;

    logic        sys_clk_in, rst_b_in, cmd_valid, data_valid, data_last;
    logic [7:0]  opcode, data, rd_data, single_status, status;
    logic [23:0] addr;
    logic [3:0]  rd_page;
    logic [8:0]  rd_byte;
    logic        cmd_ready, data_ready, flash_ready;
    int          num_errors, comparisons, cycles;
    localparam int EP_CYC = 600, PO_CYC = 300;
    flash_link_if lnk();
    flash_link_if flt();

    flash_master_end flash_master_end_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .link(lnk), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .opcode_in(opcode),
        .addr_in(addr), .data_valid_in(data_valid), .data_ready_out(data_ready), .data_in(data),
        .data_last_in(data_last), .flash_ready_out(flash_ready));
    flash_device_end #(.ERASE_PROG_CYCLES(EP_CYC), .PROG_ONLY_CYCLES(PO_CYC))
        flash_device_end_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(lnk),
        .rd_page_in(rd_page), .rd_byte_in(rd_byte), .rd_data_out(rd_data), .status_out(status));
    // Single-buffer device fed by a faulty driver.
    flash_device_end #(.ERASE_PROG_CYCLES(EP_CYC), .PROG_ONLY_CYCLES(PO_CYC), .DUAL_BUFFER(1'b0))
        flash_device_end_single_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(flt),
        .rd_page_in(rd_page), .rd_byte_in(rd_byte), .rd_data_out(), .status_out(single_status));
    flash_link_properties #(.ERASE_PROG_CYCLES(EP_CYC), .PROG_ONLY_CYCLES(PO_CYC)) props_i (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .chip_select_n(lnk.chip_select_n),
        .serial_clk(lnk.serial_clk), .mosi(lnk.mosi), .flash_ready(lnk.flash_ready));

    ////////////////////////////////////////////////////////////////////////////////
    always #5 sys_clk_in = ~sys_clk_in;

    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [23:0] adr(input logic [3:0] page, input logic [8:0] byte_pos);
        return {11'h000, page, byte_pos};
    endfunction

    // Issues one command with n write bytes and times the busy period.
    task automatic send(input logic [7:0] op, input logic [23:0] a, input int n,
                        input logic [7:0] d [4], input int busy_exp);
        int busy;
        busy = 0;
        cmd_valid <= 1'b1;
        opcode    <= op;
        addr      <= a;
        do @(posedge sys_clk_in); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            data_valid <= 1'b1;
            data       <= d[i];
            data_last  <= (i == n - 1);
            do @(posedge sys_clk_in); while (data_ready !== 1'b1);
        end
        data_valid <= 1'b0;
        do @(posedge sys_clk_in); while (flash_ready !== 1'b0);
        check("busy_status", {24'h0, status}, 32'h00);
        do begin
            @(posedge sys_clk_in);
            busy++;
        end while (flash_ready !== 1'b1);
        check("busy_min", busy >= busy_exp, 1);
        check("busy_max", busy <= busy_exp + 16, 1);
        check("ready_status", {24'h0, status}, 32'h80);
    endtask

    task automatic rd(input logic [3:0] p, input logic [8:0] b, input logic [7:0] exp);
        rd_page <= p;
        rd_byte <= b;
        repeat (2) @(posedge sys_clk_in);
        check("page_byte", {24'h0, rd_data}, {24'h0, exp});
    endtask

    // Bit-bangs nb bits on the second link, then toggles the data line.
    task automatic bang(input logic [31:0] w, input int nb, input logic [7:0] exp);
        flt.chip_select_n <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        for (int i = 0; i < nb; i++) begin
            flt.serial_clk <= 1'b0;
            flt.mosi       <= w[31 - (i % 32)];
            repeat (8) @(posedge sys_clk_in);
            flt.serial_clk <= 1'b1;
            repeat (8) @(posedge sys_clk_in);
        end
        flt.serial_clk    <= 1'b0;
        flt.chip_select_n <= 1'b1;
        flt.mosi          <= ~flt.mosi;
        repeat (8) @(posedge sys_clk_in);
        flt.serial_clk <= 1'b1;
        repeat (12) @(posedge sys_clk_in);
        check("single_status", {24'h0, single_status}, {24'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_clk_in, rst_b_in, cmd_valid, data_valid, data_last} = 5'h00;
        {opcode, data, addr, rd_page, rd_byte} = '0;
        {num_errors, comparisons, cycles} = '0;
        {flt.chip_select_n, flt.serial_clk, flt.mosi} = 3'b110;
        repeat (20) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        send(OP_THRU_B1, adr(4'h1, 9'h106), 3, '{8'h11, 8'h22, 8'h33, 8'h00}, 600);
        rd(4'h1, 9'h106, 8'h11);
        rd(4'h1, 9'h000, 8'h33);
        send(OP_THRU_B1, adr(4'h2, 9'h107), 1, '{8'h44, 8'h00, 8'h00, 8'h00}, 600);
        rd(4'h2, 9'h106, 8'h11);
        rd(4'h2, 9'h107, 8'h44);
        send(OP_ERASE_B1, adr(4'h3, 9'h0ff), 0, '{8'h00, 8'h00, 8'h00, 8'h00}, 600);
        rd(4'h3, 9'h000, 8'h33);
        rd(4'h3, 9'h107, 8'h44);
        send(OP_THRU_B2, adr(4'h4, 9'h005), 2, '{8'ha5, 8'h3c, 8'h00, 8'h00}, 600);
        rd(4'h4, 9'h006, 8'h3c);
        send(OP_ERASE_B2, adr(4'h5, 9'h000), 0, '{8'h00, 8'h00, 8'h00, 8'h00}, 600);
        rd(4'h5, 9'h005, 8'ha5);
        send(OP_THRU_B1, adr(4'h6, 9'h005), 2, '{8'hf0, 8'h0f, 8'h00, 8'h00}, 600);
        send(OP_NOERASE_B2, adr(4'h6, 9'h000), 0, '{8'h00, 8'h00, 8'h00, 8'h00}, 300);
        rd(4'h6, 9'h005, 8'ha0);
        rd(4'h6, 9'h006, 8'h0c);
        send(OP_NOERASE_B1, adr(4'h5, 9'h000), 0, '{8'h00, 8'h00, 8'h00, 8'h00}, 300);
        rd(4'h5, 9'h005, 8'ha0);
        bang({OP_ERASE_B2, adr(4'h1, 9'h000)}, 32, 8'h80);
        bang({OP_THRU_B2, adr(4'h1, 9'h000)}, 40, 8'h80);
        bang({OP_ERASE_B1, adr(4'h1, 9'h000)}, 24, 8'h80);
        bang({8'h84, adr(4'h1, 9'h000)}, 32, 8'h80);
        bang({OP_ERASE_B1, adr(4'h1, 9'h000)}, 32, 8'h00);
        tally_and_finish();
    end
endmodule
